// >>> src/wdpr_map.vh
`ifndef WDPR_MAP_VH
`define WDPR_MAP_VH

// Register offsets
`define WDPR_WDT_CTRL_OFF   8'h8f
`define WDPR_PWR_CTRL_OFF   8'h87
`define WDPR_IRQ_EN_OFF     8'he8
`define WDPR_IRQ_POL_OFF    8'he9
`define WDPR_WDT_STAT_OFF   8'h9e

// Watchdog control fields
`define WDPR_WDT_EN_BIT     7
`define WDPR_WDT_CLR_BIT    6
`define WDPR_WDT_IDLE_BIT   5
`define WDPR_PS_HI          2
`define WDPR_PS_LO          0
`define WDPR_WDT_CTRL_RMASK 8'he7

// Power control fields
`define WDPR_IDLE_BIT       0
`define WDPR_PDOWN_BIT      1
`define WDPR_WDT_FLAG_BIT   4

// Reset values
`define WDPR_SFR_RST        8'h00
`define WDPR_PORT_RST       8'hff
`define WDPR_SP_RST         8'h07

// Timing
`define WDPR_STATES_PER_MC  3'h6
`define WDPR_S5_INDEX       3'h4
`define WDPR_TIMER_BITS     14
`define WDPR_RST_MC_NEED    2
`define WDPR_WDT_RST_MC     2

`endif

// >>> src/wdpr_rst_filter.v
`timescale 1ns/1ns
`include "wdpr_map.vh"

module wdpr_rst_filter #(
  parameter NEED = `WDPR_RST_MC_NEED
) (
  input  wire clk,          // Clock
  input  wire srst,         // Synchronous reset
  input  wire sample_tick,  // Sampling instant
  input  wire pin,          // Raw reset pin level
  output reg  held_q        // Filtered reset level
);
  reg  [2:0] cnt_q;
  wire [2:0] need_c = NEED[2:0];

  // A high level only counts if seen at consecutive samples; anything between samples is ignored
  always @(posedge clk) begin
    if (srst) begin
      cnt_q  <= 3'h0;
      held_q <= 1'b0;
    end else if (sample_tick) begin
      if (!pin) begin
        cnt_q  <= 3'h0;
        held_q <= 1'b0;
      end else if (cnt_q + 3'h1 >= need_c) begin
        cnt_q  <= need_c;
        held_q <= 1'b1;
      end else begin
        cnt_q  <= cnt_q + 3'h1;
      end
    end
  end
endmodule

// >>> src/wdpr_timer.v
`timescale 1ns/1ns
`include "wdpr_map.vh"

module wdpr_timer #(
  parameter TBITS = `WDPR_TIMER_BITS
) (
  input  wire             clk,      // Clock
  input  wire             srst,     // Synchronous reset
  input  wire             clr,      // Clear timer and prescaler
  input  wire             run,      // Count enable level
  input  wire             mc_tick,  // One pulse per machine cycle
  input  wire [2:0]       sel,      // Prescale select
  output wire [TBITS-1:0] count,    // Timer value
  output reg              tout_q    // Time-out pulse
);
  reg  [7:0]       pre_q;
  reg  [TBITS-1:0] tmr_q;

  // Select code to ratio minus one; codes 001 and 010 are swapped in the table
  function [7:0] ratio_m1;
    input [2:0] s;
    begin
      case (s)
        3'b000:  ratio_m1 = 8'h01;
        3'b010:  ratio_m1 = 8'h03;
        3'b001:  ratio_m1 = 8'h07;
        3'b011:  ratio_m1 = 8'h0f;
        3'b100:  ratio_m1 = 8'h1f;
        3'b101:  ratio_m1 = 8'h3f;
        3'b110:  ratio_m1 = 8'h7f;
        default: ratio_m1 = 8'hff;
      endcase
    end
  endfunction

  wire pre_wrap = (pre_q >= ratio_m1(sel));
  wire tmr_wrap = &tmr_q;

  assign count = tmr_q;

  always @(posedge clk) begin
    if (srst || clr) begin
      pre_q  <= 8'h00;
      tmr_q  <= {TBITS{1'b0}};
      tout_q <= 1'b0;
    end else begin
      tout_q <= 1'b0;
      if (run && mc_tick) begin
        if (pre_wrap) begin
          pre_q <= 8'h00;
          tmr_q <= tmr_q + {{(TBITS-1){1'b0}}, 1'b1};
          tout_q <= tmr_wrap;
        end else begin
          pre_q <= pre_q + 8'h01;
        end
      end
    end
  end
endmodule

// >>> src/wdpr_top.v
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`include "wdpr_map.vh"

module wdpr_top #(
  parameter TBITS  = `WDPR_TIMER_BITS,
  parameter WDT_MC = `WDPR_WDT_RST_MC
) (
  input  wire       clk,               // Oscillator clock
  input  wire       srst,              // Synchronous power-on reset
  input  wire [7:0] addr,              // Register address
  input  wire [7:0] wdata,             // Write data
  input  wire       wr,                // Write strobe
  input  wire       rd,                // Read strobe
  output reg  [7:0] rdata_q,           // Read data, cycle after rd
  input  wire       rst_pin,           // External reset pin
  input  wire [7:0] port1_ext_irq,     // Port 1 irq lines, 2 to 9
  input  wire       irq_any,           // Any pending interrupt
  output reg        int_clk_q,         // Divided internal clock phase
  output reg        state5_phase2_q,   // State 5 phase 2 strobe
  output reg        mc_tick_q,         // Machine cycle end strobe
  output reg        cpu_clk_run_q,     // Processor clock running
  output reg        periph_clk_run_q,  // Peripheral clock running
  output reg        osc_run_q,         // Oscillator running
  output reg        sys_rst_q,         // System reset
  output reg  [7:0] port_init_q,       // Port value to load
  output reg  [7:0] sp_init_q,         // Stack pointer value to load
  output reg        wake_irq_q         // Port 1 wake source active
);
  localparam [2:0] M_RUN   = 3'b001;
  localparam [2:0] M_IDLE  = 3'b010;
  localparam [2:0] M_PDOWN = 3'b100;

  reg  [2:0]       mode_q;
  reg              ph_q;
  reg  [2:0]       state_q;
  reg              wdt_en_q;
  reg              wdt_clr_q;
  reg              wdt_idle_q;
  reg  [2:0]       ps_q;
  reg              idle_req_q;
  reg              pdown_req_q;
  reg              wdt_flag_q;
  reg  [7:0]       irq_en_q;
  reg  [7:0]       irq_pol_q;
  reg  [1:0]       wdt_rst_cnt_q;
  reg  [7:0]       rdata_d;

  wire             ext_rst;
  wire             tout;
  wire [TBITS-1:0] tcount;
  // Padded so the status byte is legal for short test timers too
  wire [TBITS+7:0] tcount_pad = {tcount, 8'h00};
  wire             pdown_act  = mode_q[2];
  wire             idle_act   = mode_q[1];

  // Oscillator halved; six states of two phases form one machine cycle
  wire state5_phase2 = ph_q && (state_q == `WDPR_S5_INDEX);
  wire mc_end  = ph_q && (state_q == `WDPR_STATES_PER_MC - 3'h1);
  wire sys_rst = ext_rst || (wdt_rst_cnt_q != 2'h0);

  // Level sensitive, per-line polarity
  wire [7:0] irq_lvl  = ~(port1_ext_irq ^ irq_pol_q);
  wire       wake_hit = |(irq_lvl & irq_en_q);

  wire wr_wdt = wr && (addr == `WDPR_WDT_CTRL_OFF);
  wire wr_pwr = wr && (addr == `WDPR_PWR_CTRL_OFF);
  wire wr_ien = wr && (addr == `WDPR_IRQ_EN_OFF);
  wire wr_pol = wr && (addr == `WDPR_IRQ_POL_OFF);

  // Clear acts at the next machine cycle end, as one instruction cycle later
  wire clr_now = wdt_clr_q && mc_tick_q;

  wire wdt_run = wdt_en_q && !sys_rst && !pdown_act &&
                 (!idle_act || wdt_idle_q);

  wdpr_rst_filter #(
    .NEED(`WDPR_RST_MC_NEED)
  ) u_rst_filter (
    .clk         (clk),
    .srst        (srst),
    .sample_tick (state5_phase2 || pdown_act),  // Osc stopped in power-down, so pin is watched directly
    .pin         (rst_pin),
    .held_q      (ext_rst)
  );

  wdpr_timer #(
    .TBITS(TBITS)
  ) u_timer (
    .clk     (clk),
    .srst    (srst || sys_rst),
    .clr     (clr_now),
    .run     (wdt_run),
    .mc_tick (mc_tick_q),
    .sel     (ps_q),
    .count   (tcount),
    .tout_q  (tout)
  );

  // Timing chain, frozen while the oscillator is stopped
  always @(posedge clk) begin
    if (srst) begin
      ph_q            <= 1'b0;
      state_q         <= 3'h0;
      int_clk_q       <= 1'b0;
      state5_phase2_q <= 1'b0;
      mc_tick_q       <= 1'b0;
    end else if (pdown_act) begin
      state5_phase2_q <= 1'b0;
      mc_tick_q       <= 1'b0;
    end else begin
      ph_q            <= ~ph_q;
      int_clk_q       <= ~ph_q;
      state5_phase2_q <= state5_phase2;
      mc_tick_q       <= mc_end;
      if (ph_q) begin
        state_q <= mc_end ? 3'h0 : state_q + 3'h1;
      end
    end
  end

  // Watchdog reset stretched over a few machine cycles
  always @(posedge clk) begin
    if (srst) begin
      wdt_rst_cnt_q <= 2'h0;
    end else if (tout && wdt_en_q) begin
      wdt_rst_cnt_q <= WDT_MC[1:0];
    end else if (mc_tick_q && wdt_rst_cnt_q != 2'h0) begin
      wdt_rst_cnt_q <= wdt_rst_cnt_q - 2'h1;
    end
  end

  // Control registers
  always @(posedge clk) begin
    if (srst || sys_rst) begin
      wdt_en_q   <= 1'b0;
      wdt_clr_q  <= 1'b0;
      wdt_idle_q <= 1'b0;
      ps_q       <= 3'h0;
      irq_en_q   <= `WDPR_SFR_RST;
      irq_pol_q  <= `WDPR_SFR_RST;
    end else begin
      if (wr_wdt) begin
        wdt_en_q   <= wdata[`WDPR_WDT_EN_BIT];
        wdt_idle_q <= wdata[`WDPR_WDT_IDLE_BIT];
        ps_q       <= wdata[`WDPR_PS_HI:`WDPR_PS_LO];
      end
      // A new write of one beats the self-clear
      if (wr_wdt && wdata[`WDPR_WDT_CLR_BIT]) begin
        wdt_clr_q <= 1'b1;
      end else if (clr_now) begin
        wdt_clr_q <= 1'b0;
      end
      if (wr_ien) begin
        irq_en_q <= wdata;
      end
      if (wr_pol) begin
        irq_pol_q <= wdata;
      end
    end
  end

  // Bit 4 survives every reset except power-on; it records a watchdog reset
  always @(posedge clk) begin
    if (srst) begin
      wdt_flag_q <= 1'b0;
    end else if (tout && wdt_en_q) begin
      wdt_flag_q <= 1'b1;
    end else if (wr_pwr) begin
      wdt_flag_q <= wdata[`WDPR_WDT_FLAG_BIT];
    end
  end

  // Power mode sequencing
  always @(posedge clk) begin
    if (srst || sys_rst) begin
      mode_q     <= M_RUN;
      idle_req_q  <= 1'b0;
      pdown_req_q <= 1'b0;
    end else begin
      case (mode_q)
        M_RUN: begin
          if (wr_pwr && wdata[`WDPR_PDOWN_BIT]) begin
            mode_q   <= M_PDOWN;
            pdown_req_q <= 1'b1;
          end else if (wr_pwr && wdata[`WDPR_IDLE_BIT]) begin
            mode_q     <= M_IDLE;
            idle_req_q <= 1'b1;
          end
        end
        M_IDLE: begin
          if (irq_any) begin
            mode_q     <= M_RUN;
            idle_req_q <= 1'b0;
          end
        end
        M_PDOWN: begin
          if (wake_hit) begin
            mode_q      <= M_RUN;
            pdown_req_q <= 1'b0;
          end
        end
        default: begin
          mode_q     <= M_RUN;
          idle_req_q <= 1'b0;
          pdown_req_q <= 1'b0;
        end
      endcase
    end
  end

  // Outputs
  always @(posedge clk) begin
    if (srst) begin
      cpu_clk_run_q    <= 1'b1;
      periph_clk_run_q <= 1'b1;
      osc_run_q        <= 1'b1;
      sys_rst_q        <= 1'b1;
      port_init_q      <= `WDPR_PORT_RST;
      sp_init_q        <= `WDPR_SP_RST;
      wake_irq_q       <= 1'b0;
    end else begin
      cpu_clk_run_q    <= mode_q == M_RUN;
      periph_clk_run_q <= !pdown_act;
      osc_run_q        <= !pdown_act;
      sys_rst_q        <= sys_rst;
      port_init_q      <= `WDPR_PORT_RST;
      sp_init_q        <= `WDPR_SP_RST;
      wake_irq_q       <= wake_hit;
    end
  end

  // Read mux; unmapped addresses answer zero
  always @* begin
    case (addr)
      `WDPR_WDT_CTRL_OFF: rdata_d = {wdt_en_q, wdt_clr_q, wdt_idle_q, 2'b00, ps_q} &
                                    `WDPR_WDT_CTRL_RMASK;
      `WDPR_PWR_CTRL_OFF: rdata_d = {3'b000, wdt_flag_q, 2'b00, pdown_req_q, idle_req_q};
      `WDPR_IRQ_EN_OFF:   rdata_d = irq_en_q;
      `WDPR_IRQ_POL_OFF:  rdata_d = irq_pol_q;
      `WDPR_WDT_STAT_OFF: rdata_d = tcount_pad[TBITS+7:TBITS];
      default:            rdata_d = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd ? rdata_d : 8'h00;
    end
  end
endmodule

// >>> tb/wdpr_chk.sv
`timescale 1ns/1ns
module wdpr_chk (
  input wire       clk,               // Clock
  input wire       srst,              // Reset
  input wire [7:0] addr,              // Address
  input wire       rd,                // Read strobe
  input wire [7:0] rdata_q,           // Read data
  input wire       irq_any,           // Interrupt pending
  input wire       int_clk_q,         // Internal clock phase
  input wire       cpu_clk_run_q,     // Processor clock on
  input wire       periph_clk_run_q,  // Peripheral clock on
  input wire       osc_run_q,         // Oscillator on
  input wire       sys_rst_q,         // System reset
  input wire [7:0] port_init_q,       // Port load value
  input wire [7:0] sp_init_q,         // Stack load value
  input wire       wake_irq_q         // Wake source
);
  reg srst_q;
  // Past values are stale for one edge after release
  always @(posedge clk) srst_q <= srst;
  default clocking @(posedge clk); endclocking
  default disable iff (srst || srst_q);
  property p_rd_res; rd && addr == 8'h8f |=> rdata_q[4:3] == 2'b00; endproperty
  a_rd_res: assert property (p_rd_res) else $error("reserved bits read set");
  property p_init; port_init_q == 8'hff && sp_init_q == 8'h07; endproperty
  a_init: assert property (p_init) else $error("reset load values wrong");
  property p_div; osc_run_q && $past(osc_run_q) |-> int_clk_q != $past(int_clk_q); endproperty
  a_div: assert property (p_div) else $error("internal clock not halved");
  property p_pdown_hold; !osc_run_q && !$past(osc_run_q) |-> $stable(int_clk_q); endproperty
  a_pdown_hold: assert property (p_pdown_hold) else $error("clock moves in power-down");
  property p_pdown_all; !osc_run_q |-> !periph_clk_run_q && !cpu_clk_run_q; endproperty
  a_pdown_all: assert property (p_pdown_all) else $error("clock runs without oscillator");
  property p_idle; cpu_clk_run_q |-> periph_clk_run_q; endproperty
  a_idle: assert property (p_idle) else $error("peripherals stopped");
  property p_irq_exit; osc_run_q && !cpu_clk_run_q && irq_any |-> ##[1:4] cpu_clk_run_q; endproperty
  a_irq_exit: assert property (p_irq_exit) else $error("idle not left on interrupt");
  property p_wake; !osc_run_q && wake_irq_q |-> ##[1:4] osc_run_q; endproperty
  a_wake: assert property (p_wake) else $error("no wake from power-down");
  property p_rst_len; $rose(sys_rst_q) |=> sys_rst_q [*8]; endproperty
  a_rst_len: assert property (p_rst_len) else $error("system reset too short");
  c_rst: cover property ($rose(sys_rst_q));
  c_wake: cover property (!osc_run_q ##1 osc_run_q);
  c_idle: cover property (!cpu_clk_run_q && osc_run_q ##1 cpu_clk_run_q);
endmodule
bind wdpr_top wdpr_chk i_wdpr_chk (.clk(clk), .srst(srst), .addr(addr), .rd(rd), .rdata_q(rdata_q),
  .irq_any(irq_any), .int_clk_q(int_clk_q), .cpu_clk_run_q(cpu_clk_run_q), .periph_clk_run_q(periph_clk_run_q),
  .osc_run_q(osc_run_q), .sys_rst_q(sys_rst_q), .port_init_q(port_init_q), .sp_init_q(sp_init_q),
  .wake_irq_q(wake_irq_q));

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`include "wdpr_map.vh"
module tb_top;
  reg        clk, srst, wr, rd, rst_pin, irq_any, rst_seen, seen_clr;
  reg  [7:0] addr, wdata, port1;
  wire [7:0] rdata_q, port_init_q, sp_init_q;
  wire       cpu_run, osc_run, sys_rst, mc_tick, state5;
  integer    failures, checks, seed, i, n, r, k;
  integer    ratio [0:7] = '{2, 8, 4, 16, 32, 64, 128, 256};
  // Short timer keeps each time-out within a few thousand cycles
  wdpr_top #(.TBITS(4)) i_wdpr_top (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .rst_pin(rst_pin), .port1_ext_irq(port1), .irq_any(irq_any), .int_clk_q(),
    .state5_phase2_q(state5), .mc_tick_q(mc_tick), .cpu_clk_run_q(cpu_run), .periph_clk_run_q(),
    .osc_run_q(osc_run), .sys_rst_q(sys_rst), .port_init_q(port_init_q), .sp_init_q(sp_init_q), .wake_irq_q());
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Single owner of the reset-seen flag; the stimulus only requests a clear
  always @(posedge clk) begin
    if (seen_clr) rst_seen <= 1'b0;
    else if (sys_rst === 1'b1) rst_seen <= 1'b1;
  end
  task clr_seen;
    seen_clr <= 1'b1;
    @(posedge clk);
    seen_clr <= 1'b0;
  endtask
  task results;
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task cmp(input [7:0] g, input [7:0] e);
    checks = checks + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0; wdata <= $random(seed);
  endtask
  task rd_chk(input [7:0] a, input [7:0] e);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    @(negedge clk); cmp(rdata_q, e);
  endtask
  task wait_rst(input v);
    n = 0;
    while (sys_rst !== v && n < 60000) begin
      @(posedge clk); n = n + 1;
    end
    if (n == 60000) begin
      failures = failures + 1;
      results;
    end
  endtask
  initial begin
    seed = 32'h88f917ed;
    srst = 1'b1; wr = 1'b0; rd = 1'b0; rst_pin = 1'b0; irq_any = 1'b0;
    addr = 8'h00; wdata = 8'h00; port1 = 8'h00; seen_clr = 1'b0; failures = 0; checks = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(`WDPR_WDT_CTRL_OFF, 8'h00);
    rd_chk(`WDPR_PWR_CTRL_OFF, 8'h00);
    rd_chk(8'h55, 8'h00);
    cmp(sp_init_q, 8'h07);
    rd_chk(`WDPR_WDT_STAT_OFF, 8'h00);
    n = 0;
    r = 0;
    // Any 120 running clocks hold exactly ten machine cycles
    for (i = 0; i < 120; i = i + 1) begin
      @(negedge clk);
      n = n + mc_tick;
      r = r + state5;
    end
    cmp(n[7:0], 8'h0a);
    cmp(r[7:0], 8'h0a);
    for (i = 0; i < 8; i = i + 1) begin
      r = $random(seed);
      wr_reg(`WDPR_WDT_CTRL_OFF, {2'b00, r[5:3], i[2:0]});
      rd_chk(`WDPR_WDT_CTRL_OFF, {2'b00, r[5], 2'b00, i[2:0]});
    end
    for (i = 0; i < 3; i = i + 1) begin
      k = (i == 1) ? 2 : (i == 2) ? 1 : 0;
      wr_reg(`WDPR_WDT_CTRL_OFF, 8'hc0 | k[7:0]);
      wait_rst(1'b1);
      cmp({7'h0, (n > 192 * ratio[k] - 24) && (n < 192 * ratio[k] + 24)}, 8'h01);
      wait_rst(1'b0);
      rd_chk(`WDPR_WDT_CTRL_OFF, 8'h00);
      rd_chk(`WDPR_PWR_CTRL_OFF, 8'h10);
    end
    wr_reg(`WDPR_PWR_CTRL_OFF, 8'h00);
    clr_seen;
    for (i = 0; i < 6; i = i + 1) begin
      wr_reg(`WDPR_WDT_CTRL_OFF, 8'hc0);
      repeat (200) @(posedge clk);
    end
    wr_reg(`WDPR_WDT_CTRL_OFF, 8'h00);
    repeat (1000) @(posedge clk);
    cmp({7'h0, rst_seen}, 8'h00);
    wr_reg(`WDPR_WDT_CTRL_OFF, 8'hc0);
    wr_reg(`WDPR_PWR_CTRL_OFF, 8'h01);
    repeat (3) @(posedge clk);
    cmp({7'h0, cpu_run}, 8'h00);
    repeat (1000) @(posedge clk);
    cmp({7'h0, rst_seen}, 8'h00);
    irq_any <= 1'b1;
    repeat (6) @(posedge clk);
    irq_any <= 1'b0;
    cmp({7'h0, cpu_run}, 8'h01);
    wr_reg(`WDPR_WDT_CTRL_OFF, 8'he0);
    wr_reg(`WDPR_PWR_CTRL_OFF, 8'h01);
    wait_rst(1'b1);
    wait_rst(1'b0);
    cmp({7'h0, cpu_run}, 8'h01);
    k = $random(seed) & 7;
    wr_reg(`WDPR_IRQ_EN_OFF, 8'h01 << k);
    wr_reg(`WDPR_IRQ_POL_OFF, 8'h01 << k);
    wr_reg(`WDPR_PWR_CTRL_OFF, 8'h02);
    port1 <= ~(8'h01 << k);
    repeat (30) @(posedge clk);
    cmp({7'h0, osc_run}, 8'h00);
    port1 <= 8'hff;
    repeat (8) @(posedge clk);
    cmp({7'h0, osc_run}, 8'h01);
    port1 <= 8'h00;
    clr_seen;
    rst_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rst_pin <= 1'b0;
    repeat (40) @(posedge clk);
    cmp({7'h0, rst_seen}, 8'h00);
    rst_pin <= 1'b1;
    wait_rst(1'b1);
    rst_pin <= 1'b0;
    wait_rst(1'b0);
    rd_chk(`WDPR_IRQ_EN_OFF, 8'h00);
    results;
  end
endmodule
